/* rtl/kts_if.sv */
// interfaces between the session parser and its timers and line splitter
`timescale 1ns/1ps
interface kts_tmr_if;
    logic run;
    logic kick;
    logic expire;
    modport owner (output run, output kick, input expire);
    modport timer (input run, input kick, output expire);
endinterface

interface kts_split_if;
    logic in_valid;
    logic [7:0] in_char;
    logic out_valid;
    logic [7:0] out_char;
    logic out_eol;
    modport owner (output in_valid, output in_char, input out_valid, input out_char,
        input out_eol);
    modport splitter (input in_valid, input in_char, output out_valid, output out_char,
        output out_eol);
endinterface

/* rtl/kts_pkg.sv */
// constants, types and state layout of the keypad terminal session parser
package kts_pkg;
    // ---------------------------------------------------------------
    // keys and echo characters
    // ---------------------------------------------------------------
    localparam logic [3:0] KEY_ABORT = 4'h0_00A;
    localparam logic [3:0] KEY_BLANK = 4'h0_00B;
    localparam logic [3:0] KEY_HEAD = 4'h0_00C;
    localparam logic [3:0] KEY_POINT = 4'h0_00D;
    localparam logic [3:0] KEY_MINUS = 4'h0_00E;
    localparam logic [3:0] KEY_FWD = 4'h0_00F;
    localparam logic [3:0] KEY_DIG_MAX = 4'h0_009;
    localparam logic [7:0] CH_ZERO = 8'h0030;
    localparam logic [7:0] CH_SPACE = 8'h0020;
    localparam logic [7:0] CH_HEAD = 8'h0043;
    localparam logic [7:0] CH_POINT = 8'h002E;
    localparam logic [7:0] CH_MINUS = 8'h002D;
    localparam logic [7:0] CH_RETURN = 8'h000D;
    localparam logic [7:0] CH_NEWLINE = 8'h000A;
    // ---------------------------------------------------------------
    // command numbers and entry limits
    // ---------------------------------------------------------------
    localparam logic [5:0] CMD_MIN = 6'h01;
    localparam logic [5:0] CMD_MAX = 6'h28;
    localparam logic [5:0] CMD_CLOSE = 6'h01;
    localparam logic [5:0] CMD_DATA_MSG = 6'h02;
    localparam logic [5:0] CMD_STATUS_MSG = 6'h03;
    localparam logic [5:0] CMD_PARAM_MSG = 6'h04;
    localparam logic [5:0] CMD_AUTO = 6'h0B;
    localparam logic [5:0] CMD_ALARM_LIM = 6'h1A;
    localparam logic [1:0] NUM_DIGITS = 2'h2;
    localparam logic [2:0] PAR_DIGITS = 3'h4;
    localparam int LINE_CHARS = 16;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam longint CLK_HZ = 64'd25_000_000;
    localparam longint INACT_TIME_S = 64'd60;
    localparam longint STEP_TIME_MS = 64'd500;
    localparam longint INACT_CYC = INACT_TIME_S * CLK_HZ;
    localparam longint STEP_CYC = (STEP_TIME_MS * CLK_HZ) / 64'd1000;
    // ---------------------------------------------------------------
    // session states
    // ---------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_CLOSED = 6'b00_0001,
        ST_WAIT_TX = 6'b00_0010,
        ST_READY = 6'b00_0100,
        ST_NUM = 6'b00_1000,
        ST_PARAM = 6'b01_0000,
        ST_VIEW = 6'b10_0000
    } kts_state_t;
    typedef struct packed {
        kts_state_t st;
        logic [5:0] num;
        logic [1:0] ndig;
        logic bad;
        logic [1:0] npar;
        logic pfrac;
        logic [2:0] idig;
        logic [2:0] fdig;
        logic [1:0] neg;
        logic [1:0][15:0] pint;
        logic [1:0][15:0] pfr;
        logic auto_mode;
        logic auto_tx_en;
        logic [7:0] line;
        logic back;
        logic cont;
        logic disp_clear;
        logic prompt;
        logic echo_valid;
        logic [7:0] echo_char;
        logic cmd_valid;
        logic view_show;
        logic raw_refresh;
        logic mon_refresh;
    } kts_sess_t;
endpackage

/* rtl/kts_session.sv */
// keypad terminal session parser: line control, command entry, line viewing
`timescale 1ns/1ps
module kts_session
    import kts_pkg::*;
#(
    parameter longint INACT_CYCLES = INACT_CYC,
    parameter longint STEP_CYCLES = STEP_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic key_valid,
    input wire logic [3:0] key_code,
    input wire logic auto_tx_busy,
    input wire logic [7:0] resp_lines,
    input wire logic resp_char_valid,
    input wire logic [7:0] resp_char,
    input wire logic timed_measure_cmd_done,
    output logic line_open,
    output logic auto_mode,
    output logic auto_tx_en,
    output logic disp_clear,
    output logic disp_prompt,
    output logic echo_valid,
    output logic [7:0] echo_char,
    output logic cmd_valid,
    output logic [5:0] cmd_num,
    output logic [1:0] cmd_npar,
    output logic [1:0] cmd_neg,
    output logic [31:0] cmd_int,
    output logic [31:0] cmd_frac,
    output logic view_active,
    output logic view_show,
    output logic [7:0] view_line,
    output logic term_valid,
    output logic [7:0] term_char,
    output logic term_eol,
    output logic snap_latest,
    output logic mon_refresh,
    output logic raw_refresh
);
    if (INACT_CYCLES < 1 || INACT_CYCLES > 64'hFFFF_FFFF) begin : g_bad_inact
        $error("kts_session: INACT_CYCLES out of range");
    end
    if (STEP_CYCLES < 1 || STEP_CYCLES > 64'hFFFF_FFFF) begin : g_bad_step
        $error("kts_session: STEP_CYCLES out of range");
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic is_digit(input logic [3:0] k);
        return k <= KEY_DIG_MAX;
    endfunction

    function automatic logic [15:0] dec_push(input logic [15:0] v, input logic [3:0] d);
        logic [19:0] t;
        t = 20'(v) * 20'd10 + 20'(d);
        return t[15:0];
    endfunction

    function automatic logic [7:0] key_echo(input logic [3:0] k);
        logic [7:0] c;
        c = CH_ZERO + 8'(k);
        case (k)
            KEY_BLANK: c = CH_SPACE;
            KEY_HEAD: c = CH_HEAD;
            KEY_POINT: c = CH_POINT;
            KEY_MINUS: c = CH_MINUS;
            KEY_FWD: c = CH_RETURN;
            default: c = CH_ZERO + 8'(k);
        endcase
        return c;
    endfunction

    // ---------------------------------------------------------------
    // state and sub-blocks
    // ---------------------------------------------------------------
    kts_sess_t s_q;
    kts_sess_t s_d;

    kts_tmr_if inact_if ();
    kts_tmr_if step_if ();
    kts_split_if split_if ();

    logic is_open;
    logic [7:0] last_line;
    assign is_open = (s_q.st != ST_CLOSED) && (s_q.st != ST_WAIT_TX);
    assign last_line = (resp_lines == 8'h00) ? 8'h00 : resp_lines - 8'h01;

    assign inact_if.run = is_open;
    assign inact_if.kick = key_valid;
    assign step_if.run = (s_q.st == ST_VIEW) && s_q.cont;
    assign step_if.kick = key_valid;
    assign split_if.in_valid = resp_char_valid;
    assign split_if.in_char = resp_char;

    kts_timer #(
        .CYCLES(32'(INACT_CYCLES))
    ) u_inact (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tif(inact_if)
    );

    kts_timer #(
        .CYCLES(32'(STEP_CYCLES))
    ) u_step (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tif(step_if)
    );

    kts_splitter #(
        .WIDTH(LINE_CHARS)
    ) u_split (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sif(split_if)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic fin;
        logic bad;
        logic cur;
        logic multi;
        logic [15:0] nv;
        nv = 16'h0000;
        fin = 1'b0;
        bad = s_q.bad;
        cur = s_q.npar[1];
        multi = 1'b0;
        s_d = s_q;
        s_d.disp_clear = 1'b0;
        s_d.prompt = 1'b0;
        s_d.echo_valid = 1'b0;
        s_d.cmd_valid = 1'b0;
        s_d.view_show = 1'b0;
        // maintenance mode keeps automatic output off
        s_d.auto_tx_en = !is_open && s_q.auto_mode;
        // raw table follows a timed measurement only in maintenance
        s_d.raw_refresh = timed_measure_cmd_done && !s_q.auto_mode;
        s_d.mon_refresh = !s_q.auto_mode;
        if (key_valid && (s_q.st == ST_NUM || s_q.st == ST_PARAM)) begin
            // letter keys except abort echoed as command symbols
            s_d.echo_valid = (key_code != KEY_ABORT);
            s_d.echo_char = key_echo(key_code);
        end
        case (s_q.st)
            ST_CLOSED: begin
                // only the forward key is seen
                if (key_valid && key_code == KEY_FWD) begin
                    if (auto_tx_busy) begin
                        s_d.st = ST_WAIT_TX;
                    end else begin
                        s_d.st = ST_READY;
                        s_d.prompt = 1'b1;
                    end
                end
            end
            ST_WAIT_TX: begin
                if (!auto_tx_busy) begin
                    s_d.st = ST_READY;
                    s_d.prompt = 1'b1;
                end
            end
            ST_READY: begin
                if (key_valid && key_code == KEY_HEAD) begin
                    s_d.st = ST_NUM;
                    s_d.echo_valid = 1'b1;
                    s_d.echo_char = key_echo(key_code);
                    s_d.num = 6'h00;
                    s_d.ndig = 2'h0;
                    s_d.bad = 1'b0;
                    s_d.npar = 2'h0;
                    s_d.neg = 2'h0;
                    s_d.pint = '0;
                    s_d.pfr = '0;
                end
            end
            ST_NUM: begin
                if (key_valid) begin
                    if (is_digit(key_code)) begin
                        if (s_q.ndig == NUM_DIGITS) begin
                            s_d.bad = 1'b1;
                        end else begin
                            nv = dec_push(16'(s_q.num), key_code);
                            // a number past the table must not wrap into range
                            s_d.bad = s_q.bad || (nv > 16'(CMD_MAX));
                            s_d.num = 6'(nv);
                            s_d.ndig = s_q.ndig + 2'h1;
                        end
                    end else if (key_code == KEY_BLANK) begin
                        s_d.bad = s_q.bad || (s_q.ndig == 2'h0);
                        s_d.st = ST_PARAM;
                        s_d.npar = 2'h1;
                        s_d.pfrac = 1'b0;
                        s_d.idig = 3'h0;
                        s_d.fdig = 3'h0;
                    end else if (key_code == KEY_FWD) begin
                        fin = 1'b1;
                        bad = s_q.bad || (s_q.ndig == 2'h0);
                    end else begin
                        // abort or stray letter spoils the line
                        s_d.bad = 1'b1;
                    end
                end
            end
            ST_PARAM: begin
                if (key_valid) begin
                    if (is_digit(key_code) && !s_q.pfrac) begin
                        if (s_q.idig == PAR_DIGITS) begin
                            s_d.bad = 1'b1;
                        end else begin
                            s_d.pint[cur] = dec_push(s_q.pint[cur], key_code);
                            s_d.idig = s_q.idig + 3'h1;
                        end
                    end else if (is_digit(key_code)) begin
                        if (s_q.fdig == PAR_DIGITS) begin
                            s_d.bad = 1'b1;
                        end else begin
                            s_d.pfr[cur] = dec_push(s_q.pfr[cur], key_code);
                            s_d.fdig = s_q.fdig + 3'h1;
                        end
                    end else if (key_code == KEY_MINUS) begin
                        s_d.bad = s_q.bad || s_q.neg[cur] || s_q.idig != 3'h0 || s_q.pfrac;
                        s_d.neg[cur] = 1'b1;
                    end else if (key_code == KEY_POINT) begin
                        s_d.bad = s_q.bad || s_q.pfrac || s_q.idig == 3'h0;
                        s_d.pfrac = 1'b1;
                    end else if (key_code == KEY_BLANK || key_code == KEY_FWD) begin
                        bad = s_q.bad || s_q.idig == 3'h0 || (s_q.pfrac && s_q.fdig == 3'h0);
                        if (key_code == KEY_FWD) begin
                            fin = 1'b1;
                        end else begin
                            // a third parameter is not part of the format
                            s_d.bad = bad || cur;
                            s_d.npar = 2'h2;
                            s_d.pfrac = 1'b0;
                            s_d.idig = 3'h0;
                            s_d.fdig = 3'h0;
                        end
                    end else begin
                        s_d.bad = 1'b1;
                    end
                end
            end
            ST_VIEW: begin
                if (key_valid) begin
                    case (key_code)
                        KEY_ABORT: begin
                            s_d.st = ST_READY;
                            s_d.prompt = 1'b1;
                            s_d.cont = 1'b0;
                        end
                        KEY_BLANK: begin
                            s_d.back = 1'b1;
                            s_d.cont = 1'b0;
                            if (s_q.line != 8'h00) begin
                                s_d.line = s_q.line - 8'h01;
                                s_d.view_show = 1'b1;
                            end
                        end
                        KEY_FWD: begin
                            s_d.back = 1'b0;
                            s_d.cont = 1'b0;
                            if (s_q.line < last_line) begin
                                s_d.line = s_q.line + 8'h01;
                                s_d.view_show = 1'b1;
                            end
                        end
                        KEY_HEAD: begin
                            s_d.cont = 1'b1;
                        end
                        default: begin
                            s_d.cont = s_q.cont;
                        end
                    endcase
                end else if (step_if.expire) begin
                    // paced step, stops at either end
                    if (s_q.back && s_q.line != 8'h00) begin
                        s_d.line = s_q.line - 8'h01;
                        s_d.view_show = 1'b1;
                    end else if (!s_q.back && s_q.line < last_line) begin
                        s_d.line = s_q.line + 8'h01;
                        s_d.view_show = 1'b1;
                    end else begin
                        s_d.cont = 1'b0;
                    end
                end
            end
            default: begin
                s_d.st = ST_CLOSED;
            end
        endcase
        if (fin) begin
            s_d.st = ST_READY;
            // reject malformed or out of range
            if (bad || s_q.num < CMD_MIN || s_q.num > CMD_MAX) begin
                s_d.prompt = 1'b1;
            end else begin
                s_d.cmd_valid = 1'b1;
                multi = (s_q.num == CMD_DATA_MSG) || (s_q.num == CMD_STATUS_MSG) ||
                    (s_q.num == CMD_PARAM_MSG) || (s_q.num == CMD_ALARM_LIM);
                if (s_q.num == CMD_CLOSE) begin
                    s_d.st = ST_CLOSED;
                end else if (multi) begin
                    s_d.st = ST_VIEW;
                    s_d.disp_clear = 1'b1;
                    s_d.view_show = 1'b1;
                    s_d.line = 8'h00;
                    s_d.back = 1'b0;
                    s_d.cont = 1'b0;
                end else begin
                    s_d.prompt = 1'b1;
                    if (s_q.num == CMD_AUTO && s_q.npar == 2'h1 && s_q.pint[0] <= 16'h0001) begin
                        s_d.auto_mode = s_q.pint[0][0];
                    end
                end
            end
        end
        // inactivity close, a key in the same cycle wins
        if (is_open && inact_if.expire && !key_valid) begin
            s_d.st = ST_CLOSED;
            s_d.cont = 1'b0;
            s_d.prompt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= ST_CLOSED;
            s_q.auto_mode <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // automatic mode serves the latest finished measurement
    assign snap_latest = s_q.auto_mode;
    assign line_open = (s_q.st != ST_CLOSED) && (s_q.st != ST_WAIT_TX);
    assign auto_mode = s_q.auto_mode;
    assign auto_tx_en = s_q.auto_tx_en;
    assign disp_clear = s_q.disp_clear;
    assign disp_prompt = s_q.prompt;
    assign echo_valid = s_q.echo_valid;
    assign echo_char = s_q.echo_char;
    assign cmd_valid = s_q.cmd_valid;
    assign cmd_num = s_q.num;
    assign cmd_npar = s_q.npar;
    assign cmd_neg = s_q.neg;
    assign cmd_int = s_q.pint;
    assign cmd_frac = s_q.pfr;
    assign view_active = (s_q.st == ST_VIEW);
    assign view_show = s_q.view_show;
    assign view_line = s_q.line;
    assign term_valid = split_if.out_valid;
    assign term_char = split_if.out_char;
    assign term_eol = split_if.out_eol;
    assign mon_refresh = s_q.mon_refresh;
    assign raw_refresh = s_q.raw_refresh;
endmodule

/* rtl/kts_splitter.sv */
// breaks the response character stream into display-width groups
`timescale 1ns/1ps
module kts_splitter
    import kts_pkg::*;
#(
    parameter int WIDTH = LINE_CHARS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    kts_split_if.splitter sif
);
    if (WIDTH < 1 || WIDTH > 255) begin : g_bad_width
        $error("kts_splitter: WIDTH out of range");
    end

    typedef struct packed {
        logic [7:0] cnt;
        logic out_valid;
        logic [7:0] out_char;
        logic out_eol;
    } kts_spl_t;

    kts_spl_t s_q;
    kts_spl_t s_d;

    assign sif.out_valid = s_q.out_valid;
    assign sif.out_char = s_q.out_char;
    assign sif.out_eol = s_q.out_eol;

    always_comb begin
        s_d = s_q;
        s_d.out_valid = 1'b0;
        s_d.out_eol = 1'b0;
        if (sif.in_valid) begin
            if (sif.in_char == CH_NEWLINE) begin
                // a source line end closes the group without a character
                s_d.out_eol = 1'b1;
                s_d.cnt = 8'h00;
            end else begin
                s_d.out_valid = 1'b1;
                s_d.out_char = sif.in_char;
                if (s_q.cnt == 8'(WIDTH - 1)) begin
                    s_d.out_eol = 1'b1;
                    s_d.cnt = 8'h00;
                end else begin
                    s_d.cnt = s_q.cnt + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

/* rtl/kts_timer.sv */
// cycle-count interval timer with restart, used for timeout and stepping
`timescale 1ns/1ps
module kts_timer
    import kts_pkg::*;
#(
    parameter int unsigned CYCLES = 32'd1000
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    kts_tmr_if.timer tif
);
    if (CYCLES < 1) begin : g_bad_cycles
        $error("kts_timer: CYCLES must be at least one");
    end

    typedef struct packed {
        logic [31:0] cnt;
        logic expire;
    } kts_tmr_t;

    kts_tmr_t s_q;
    kts_tmr_t s_d;

    assign tif.expire = s_q.expire;

    // ---------------------------------------------------------------
    // counter
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.expire = 1'b0;
        if (tif.kick || !tif.run) begin
            s_d.cnt = 32'h0000_0000;
        end else if (s_q.cnt == CYCLES - 32'd1) begin
            s_d.cnt = 32'h0000_0000;
            s_d.expire = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

/* test/kts_session_monitor.sv */
// port assertions for the keypad session parser
`timescale 1ns/1ps
module kts_session_monitor import kts_pkg::*; (
    input logic sys_clk,
    input logic rst_n,
    input logic key_valid,
    input logic [3:0] key_code,
    input logic auto_tx_busy,
    input logic line_open,
    input logic auto_mode,
    input logic auto_tx_en,
    input logic disp_prompt,
    input logic disp_clear,
    input logic cmd_valid,
    input logic [5:0] cmd_num,
    input logic view_active,
    input logic [7:0] view_line
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_op; !line_open && !auto_tx_busy && key_valid && key_code == KEY_FWD
        |=> line_open && disp_prompt; endproperty
    a_op: assert property (p_op) else $error("no open");
    property p_wait; !line_open && auto_tx_busy |=> !line_open; endproperty
    a_wait: assert property (p_wait) else $error("early open");
    property p_drop; !line_open && key_valid && key_code != KEY_FWD |=> !cmd_valid; endproperty
    a_drop: assert property (p_drop) else $error("key kept");
    property p_cls; cmd_valid && cmd_num == CMD_CLOSE |-> !line_open ##1
        (auto_tx_en == auto_mode); endproperty
    a_cls: assert property (p_cls) else $error("no close");
    property p_one; cmd_valid && cmd_num == CMD_DATA_MSG
        |-> view_active && view_line == 8'h00 && disp_clear; endproperty
    a_one: assert property (p_one) else $error("no first line");
    property p_ab; view_active && key_valid && key_code == KEY_ABORT
        |=> !view_active && disp_prompt; endproperty
    a_ab: assert property (p_ab) else $error("no abort");
    property p_bk; view_active && key_valid && key_code == KEY_BLANK && view_line != 8'h00
        |=> view_line == $past(view_line) - 8'h01; endproperty
    a_bk: assert property (p_bk) else $error("no back step");
    property p_man; !auto_mode |=> !auto_tx_en; endproperty
    a_man: assert property (p_man) else $error("auto output");
endmodule
bind kts_session kts_session_monitor u_mon (.*);

/* test/kts_term_model.sv */
// keypad terminal model sending keys and whole command lines
`timescale 1ns/1ps
module kts_term_model import kts_pkg::*; (
    input logic sys_clk,
    output logic key_valid = 1'h0,
    output logic [3:0] key_code = 4'h0
);
    task automatic press(input logic [3:0] k);
        @(negedge sys_clk) key_valid = 1'h1;
        key_code = k;
        @(negedge sys_clk) key_valid = 1'h0;
        // inverted on release so a stale code never matches
        key_code = ~k;
    endtask
    task automatic line(input logic [23:0] s, input int n);
        for (int i = n - 1; i >= 0; i--) press(s[4 * i +: 4]);
    endtask
endmodule

/* test/tb_top.sv */
// self-checking bench for the keypad terminal session parser
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %0d got %0d", n, e, g); end end
module tb_top;
    import kts_pkg::*;
    logic sys_clk = 1'h0, rst_n = 1'h0, auto_tx_busy = 1'h0, key_valid, line_open, auto_mode;
    logic view_active, cmd_valid, echo_valid, term_valid, term_eol, snap_latest, mon_refresh;
    logic raw_refresh, resp_char_valid = 1'h0, timed_measure_cmd_done = 1'h0;
    logic [1:0] cmd_npar, cmd_neg;
    logic [5:0] cmd_num;
    logic [31:0] cmd_int, cmd_frac;
    logic [7:0] echo_char, term_char, resp_char = 8'h00, e_exp, t_exp;
    logic [7:0] echo_q[$], term_q[$];
    logic [73:0] c_last = '0;
    logic [3:0] key_code;
    logic [7:0] resp_lines = 8'h02, view_line;
    logic [31:0] seed = 32'he7a2;
    int fail_count = 0, tests_run = 0, n_cmd = 0, x = 0, n_term = 0, n_eol = 0;
    always #20 sys_clk = ~sys_clk;
    // pulses are looked at mid-cycle, while they stand
    always @(negedge sys_clk) begin
        if (cmd_valid === 1'h1) begin
            n_cmd++;
            c_last = {cmd_num, cmd_npar, cmd_neg, cmd_int, cmd_frac};
        end
        if (echo_valid === 1'h1) begin
            e_exp = (echo_q.size() > 0) ? echo_q.pop_front() : 8'h00;
            `CHK("echo", e_exp, echo_char)
        end
        if (term_valid === 1'h1) begin
            n_term++;
            t_exp = (term_q.size() > 0) ? term_q.pop_front() : 8'h00;
            `CHK("term", t_exp, term_char)
        end
        if (term_eol === 1'h1) begin
            n_eol++;
            `CHK("group", 16, n_term)
            n_term = 0;
        end
    end
    kts_term_model u_term (.*);
    kts_session #(.INACT_CYCLES(200), .STEP_CYCLES(20)) u_kts_session (.*, .auto_tx_en(),
        .disp_clear(), .disp_prompt(), .view_show());
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] echo_of(input logic [3:0] k);
        string m = "0123456789? C.-";
        return (k == 4'hF) ? 8'h0D : 8'(m[k]);
    endfunction
    task automatic cmd(input logic [23:0] s, input int n);
        for (int i = n - 1; i >= 0; i--) echo_q.push_back(echo_of(s[4 * i +: 4]));
        send(s, n);
    endtask
    task automatic send(input logic [23:0] s, input int n);
        u_term.line(s, n);
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        close_out();
    end
    initial begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1'h1;
        seed = lfsr(seed);
        send({20'h0_0000, 1'h0, seed[2:0]}, 1);
        `CHK("open", 1'h0, line_open)
        auto_tx_busy = 1'h1;
        send(24'hF, 1);
        `CHK("open", 1'h0, line_open)
        auto_tx_busy = 1'h0;
        repeat (3) @(negedge sys_clk);
        `CHK("open", 1'h1, line_open)
        resp_lines = 8'h02 + 8'(seed[7:5]);
        cmd(24'hC2F, 3);
        for (int i = 1; i < resp_lines; i++) send(24'hF, 1);
        x = resp_lines - 1;
        `CHK("line", x, view_line)
        send(24'hBD, 2);
        `CHK("line", x - 1, view_line)
        send(24'hC, 1);
        repeat (20 * resp_lines) @(negedge sys_clk);
        `CHK("line", 0, view_line)
        send(24'hA, 1);
        `CHK("view", 1'h0, view_active)
        $display("test view done");
        x = n_cmd;
        cmd(24'hC41F, 4);
        `CHK("cmds", x, n_cmd)
        cmd(24'hC99F, 4);
        `CHK("cmds", x, n_cmd)
        cmd(24'hC6_BE12, 6);
        cmd(24'hD0_5B7F, 6);
        `CHK("cmd", ({6'h06, 2'h2, 2'h1, 32'h0007_000C, 32'h0000_0005}), c_last)
        cmd(24'hC1_1B0F, 6);
        `CHK("auto", 1'h0, auto_mode)
        timed_measure_cmd_done = 1'h1;
        @(negedge sys_clk);
        timed_measure_cmd_done = 1'h0;
        `CHK("raw", 1'h1, raw_refresh)
        `CHK("snap", 1'h0, snap_latest)
        cmd(24'hC1_1B1F, 6);
        `CHK("mon", 1'h0, mon_refresh)
        cmd(24'hC1F, 3);
        `CHK("open", 1'h0, line_open)
        send(24'hF, 1);
        `CHK("open", 1'h1, line_open)
        repeat (190) @(negedge sys_clk);
        `CHK("open", 1'h1, line_open)
        repeat (30) @(negedge sys_clk);
        `CHK("open", 1'h0, line_open)
        $display("test mode done");
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            resp_char_valid = 1'h1;
            resp_char = seed[7:0] | 8'h20;
            term_q.push_back(resp_char);
            @(negedge sys_clk);
        end
        resp_char_valid = 1'h0;
        repeat (2) @(negedge sys_clk);
        `CHK("groups", 2, n_eol)
        `CHK("echo left", 0, echo_q.size())
        `CHK("term left", 0, term_q.size())
        $display("test split done");
        close_out();
    end
endmodule
